// File: tb/sirqcr_host.sv
`timescale 1ns/100ps
module sirqcr_host (
  input  wire logic clk,
  input  wire logic line,
  output logic        oe,
  output logic        o,
  output logic [15:0] bits,
  output logic        done
);
  initial begin
    oe = 1'b0;
    o = 1'b1;
    bits = 16'h0;
    done = 1'b0;
  end
  task automatic drive(input logic v, input int n);
    repeat (n) begin
      @(posedge clk);
      #1 oe = 1'b1;
      o = v;
    end
  endtask
  // host drives the 4-clock start of each cycle and picks the stop width
  task automatic cycle(input int stop_len);
    logic [53:0] lows;
    lows = 54'h0;
    drive(1'b0, 4);
    drive(1'b1, 1);
    @(posedge clk);
    #1 oe = 1'b0;
    for (int s = 1; s < 52; s++) begin
      @(posedge clk);
      lows[s] = (line === 1'b0);
    end
    for (int k = 0; k < 16; k++) bits[k] = !(|lows[3*k+2 +: 3]);
    drive(1'b0, stop_len);
    drive(1'b1, 1);
    @(posedge clk);
    #1 oe = 1'b0;
    repeat (2) @(posedge clk);
    done = 1'b1;
    #1 done = 1'b0;
  endtask
endmodule

// File: tb/sirqcr_top_props.sv
`timescale 1ns/100ps
module sirqcr_top_props #(
  parameter int unsigned N_IRQ = 16
) (
  input wire logic             CLK,
  input wire logic             RST_N,
  input wire logic             BUS_RESET_DRIVE,
  input wire logic             SERIAL_IRQ_ENABLE,
  input wire logic             PIN_MUX_SEL,
  input wire logic             ADDRESS_DECODE_OUTPUT,
  input wire logic [N_IRQ-1:0] IRQ,
  input wire logic             SIRQ_O,
  input wire logic             SIRQ_OE,
  input wire logic             CLKRUN_N_I,
  input wire logic             CLKRUN_N_O,
  input wire logic             CLKRUN_N_OE,
  input wire logic             QUIET_MODE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // cycles the clock-run line has stood high, saturating
  logic [3:0] hi_q;
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N) hi_q <= 4'h0;
    else hi_q <= !CLKRUN_N_I ? 4'h0 : hi_q + 4'(hi_q != 4'hF);
  property p_rst_off; BUS_RESET_DRIVE [*4] |-> !SIRQ_OE; endproperty
  a_rst_off: assert property (p_rst_off) else $error("sirq driven in reset");
  property p_rst_mode; BUS_RESET_DRIVE [*5] |-> !QUIET_MODE; endproperty
  a_rst_mode: assert property (p_rst_mode) else $error("quiet in reset");
  property p_od; PIN_MUX_SEL && CLKRUN_N_OE |-> !CLKRUN_N_O; endproperty
  a_od: assert property (p_od) else $error("clkrun driven high");
  property p_req; PIN_MUX_SEL && SERIAL_IRQ_ENABLE && !BUS_RESET_DRIVE && hi_q > 4'h6 && $changed(IRQ)
    |-> ##[0:1] CLKRUN_N_OE; endproperty
  a_req: assert property (p_req) else $error("no clkrun request");
  property p_hold; PIN_MUX_SEL && $rose(CLKRUN_N_OE)
    |=> CLKRUN_N_OE ##1 !CLKRUN_N_OE; endproperty
  a_hold: assert property (p_hold) else $error("clkrun hold wrong");
  property p_en; PIN_MUX_SEL && !SERIAL_IRQ_ENABLE |-> !CLKRUN_N_OE; endproperty
  a_en: assert property (p_en) else $error("clkrun while disabled");
  property p_mux; !PIN_MUX_SEL |-> CLKRUN_N_OE && CLKRUN_N_O == ADDRESS_DECODE_OUTPUT;
  endproperty
  a_mux: assert property (p_mux) else $error("pin mux wrong");
  property p_frame; !QUIET_MODE && SIRQ_OE && !SIRQ_O
    |=> SIRQ_OE && SIRQ_O ##1 !SIRQ_OE; endproperty
  a_frame: assert property (p_frame) else $error("frame drive wrong");
endmodule

// File: tb/tb_serial_irq_clock_run.sv
`timescale 1ns/100ps
module tb_serial_irq_clock_run;
  logic        clk = 1'b0, rst_n = 1'b0, brd = 1'b0, en = 1'b1, mux = 1'b1, ado = 1'b0;
  logic        gen_low = 1'b0, s_o, s_oe, c_o, c_oe, qm, h_oe, h_o, done;
  logic [15:0] irq = 16'hFFFF, bits, expq[$];
  int          n_errors = 0, cmp_count = 0, r, l;
  // both lines are pulled up when released
  wire         sirq = h_oe ? h_o : (s_oe ? s_o : 1'b1);
  wire         ckr = gen_low ? 1'b0 : (c_oe ? c_o : 1'b1);
  always #5 clk = ~clk;
  sirqcr_top #(.N_IRQ(16)) uut (.CLK(clk), .RST_N(rst_n), .BUS_RESET_DRIVE(brd),
    .SERIAL_IRQ_ENABLE(en), .PIN_MUX_SEL(mux), .ADDRESS_DECODE_OUTPUT(ado), .IRQ(irq),
    .SIRQ_I(sirq), .SIRQ_O(s_o), .SIRQ_OE(s_oe), .CLKRUN_N_I(ckr), .CLKRUN_N_O(c_o),
    .CLKRUN_N_OE(c_oe), .QUIET_MODE(qm));
  sirqcr_host host (.clk(clk), .line(sirq), .oe(h_oe), .o(h_o), .bits(bits), .done(done));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compares=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // counts clock requests; stops early once the serial line is seen low
  task automatic watch(input int n);
    logic p;
    r = 0;
    l = 0;
    p = c_oe;
    for (int i = 0; i < n && l == 0; i++) begin
      @(negedge clk);
      r += int'(c_oe && !p);
      l += int'(sirq === 1'b0);
      p = c_oe;
    end
  endtask
  task automatic ser(input int stop);
    expq.push_back(irq & 16'hFFFE);
    host.cycle(stop);
    @(negedge clk);
  endtask
  task automatic chg;
    @(negedge clk);
    irq = irq ^ (16'h0002 | 16'($urandom));
  endtask
  always @(posedge done)
    if (expq.size() == 0) check(16'h0, 16'h1);
    else check(bits & 16'hFFFE, expq.pop_front());
  initial begin
    r = $urandom(68742);
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    ser(3);
    check({15'h0, qm}, 16'h0);
    gen_low = 1'b1;
    chg;
    watch(12);
    check(16'(r + l), 16'h0);
    gen_low = 1'b0;
    watch(20);
    check({15'h0, r > 1}, 16'h1);
    ser(2);
    check({15'h0, qm}, 16'h1);
    watch(20);
    check(16'(r + l), 16'h0);
    gen_low = 1'b1;
    chg;
    watch(12);
    check(16'(l), 16'h1);
    ser(3);
    check({15'h0, qm}, 16'h0);
    gen_low = 1'b0;
    en = 1'b0;
    chg;
    watch(15);
    check(16'(r), 16'h0);
    en = 1'b1;
    ser(3);
    mux = 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      ado = 1'($urandom);
      #1 check({14'h0, c_oe, c_o}, {14'h0, 1'b1, ado});
    end
    @(negedge clk);
    mux = 1'b1;
    repeat (10) @(negedge clk);
    irq = irq ^ 16'h0100;
    #2 check({15'h0, c_oe}, 16'h1);
    ser(3);
    ser(2);
    brd = 1'b1;
    repeat (8) @(negedge clk);
    check({14'h0, qm, s_oe}, 16'h0);
    brd = 1'b0;
    repeat (5) @(negedge clk);
    end_of_test;
  end
endmodule
bind sirqcr_top sirqcr_top_props #(.N_IRQ(N_IRQ)) u_props (.*);

// File: verilog/sirqcr_chg_det.sv
`timescale 1ns/100ps
// clockless change detector: each irq line toggles a rise flop and a fall flop, whose xor is its flag,
// the flag compares against a clocked copy; pending stays up until the clocked
// side acknowledges by copying the flags.
module sirqcr_chg_det #(
  parameter int unsigned N = 16
) (
  input  wire logic         rst_n,
  input  wire logic         clk,
  input  wire logic [N-1:0] irq,
  sirqcr_chg_if.det         chg
);
  logic [N-1:0] tog;
  logic [N-1:0] ack_q;
  logic [N-1:0] ack_d;
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_edge
      logic rise_t;
      logic fall_t;
      always_ff @(posedge irq[i] or negedge rst_n) begin
        if (!rst_n) rise_t <= 1'b0;
        else rise_t <= ~rise_t;
      end
      always_ff @(negedge irq[i] or negedge rst_n) begin
        if (!rst_n) fall_t <= 1'b0;
        else fall_t <= ~fall_t;
      end
      assign tog[i] = rise_t ^ fall_t;
    end
  endgenerate
  always_comb begin
    ack_d = ack_q;
    if (chg.clear) ack_d = tog;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ack_q <= '0;
    else ack_q <= ack_d;
  end
  assign chg.pending = |(tog ^ ack_q);
endmodule

// File: verilog/sirqcr_chg_if.sv
`timescale 1ns/100ps
interface sirqcr_chg_if;
  logic pending;
  logic clear;
  modport det (output pending, input clear);
  modport use_side (input pending, output clear);
endinterface

// File: verilog/sirqcr_pkg.sv
package sirqcr_pkg;
  // serial interrupt frame timing in PCI clocks, then frame count and counter widths in bits
  localparam int unsigned START_MIN_LOW   = 4;
  localparam int unsigned STOP_QUIET_LOW  = 2;
  localparam int unsigned STOP_CONT_LOW   = 3;
  localparam int unsigned FRAME_CLOCKS    = 3;
  localparam int unsigned NUM_FRAMES      = 17;
  localparam int unsigned LOW_CNT_W       = 4;
  localparam int unsigned SLOT_CNT_W      = 8;
  // clock-run timing, in PCI clocks
  localparam int unsigned CLKRUN_HOLD_EDGES = 2;
  localparam int unsigned CLKRUN_IDLE_EDGES = 2;
  // mode after reset: continuous
  localparam logic        MODE_QUIET_RST  = 1'b0;
  // pin mux select value that routes the clock-run function to the shared pin
  localparam logic        PIN_SEL_CLKRUN  = 1'b1;
  typedef enum logic [2:0] {
    SIRQCR_IDLE, SIRQCR_START, SIRQCR_FRAMES, SIRQCR_STOP_WAIT, SIRQCR_STOP_LOW
  } sirqcr_state_t;
endpackage

// File: verilog/sirqcr_top.sv
`timescale 1ns/100ps
module sirqcr_top
  import sirqcr_pkg::*;
#(
  parameter int unsigned N_IRQ = 16
) (
  input  wire logic             CLK,
  input  wire logic             RST_N,
  input  wire logic             BUS_RESET_DRIVE,
  input  wire logic             SERIAL_IRQ_ENABLE,
  input  wire logic             PIN_MUX_SEL,
  input  wire logic             ADDRESS_DECODE_OUTPUT,
  input  wire logic [N_IRQ-1:0] IRQ,
  input  wire logic             SIRQ_I,
  output logic                  SIRQ_O,
  output logic                  SIRQ_OE,
  input  wire logic             CLKRUN_N_I,
  output logic                  CLKRUN_N_O,
  output logic                  CLKRUN_N_OE,
  output logic                  QUIET_MODE
);
  import sirqcr_pkg::*;
  sirqcr_chg_if chg ();
  sirqcr_chg_det #(.N(N_IRQ)) u_det (
    .rst_n (RST_N),
    .clk   (CLK),
    .irq   (IRQ),
    .chg   (chg)
  );
  logic          rst_all_n;
  logic [2:0]    crn_s;
  logic [2:0]    pnd_s;
  logic [2:0]    brd_s;
  logic [N_IRQ-1:0] irq_a;
  logic [N_IRQ-1:0] irq_b;
  assign rst_all_n = RST_N;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      crn_s <= 3'h7;
      pnd_s <= 3'h0;
      brd_s <= 3'h7;
      irq_a <= '1;
      irq_b <= '1;
    end else begin
      crn_s <= {crn_s[1:0], CLKRUN_N_I};
      pnd_s <= {pnd_s[1:0], chg.pending};
      brd_s <= {brd_s[1:0], BUS_RESET_DRIVE};
      irq_a <= IRQ;
      irq_b <= irq_a;
    end
  end
  logic crn_hi, pend, in_rst;
  assign crn_hi = crn_s[2] & crn_s[1];
  assign pend   = pnd_s[2] & pnd_s[1];
  assign in_rst = brd_s[2] & brd_s[1];
  logic sirq_hi;
  logic sirq_q;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) sirq_q <= 1'b1;
    else sirq_q <= SIRQ_I; // serial irq is synchronous to the PCI clock
  end
  assign sirq_hi = sirq_q;
  // serial irq slave state machine
  sirqcr_state_t           st_q, st_d;
  logic [LOW_CNT_W-1:0]    low_q, low_d;
  logic [SLOT_CNT_W-1:0]   slot_q, slot_d;
  logic                    quiet_q, quiet_d;
  logic                    so_q, so_d, soe_q, soe_d, drove_q, drove_d;
  logic                    clr_q, clr_d, carry_q, carry_d;
  logic [1:0]              ph;
  logic [SLOT_CNT_W-1:0]   frame;
  assign ph    = 2'(slot_q % FRAME_CLOCKS);
  assign frame = SLOT_CNT_W'(slot_q / FRAME_CLOCKS);
  always_comb begin
    st_d = st_q;
    low_d = low_q;
    slot_d = slot_q;
    quiet_d = quiet_q;
    so_d = 1'b1;
    soe_d = 1'b0;
    drove_d = drove_q;
    clr_d = 1'b0;
    carry_d = carry_q;
    unique case (st_q)
      SIRQCR_IDLE: begin
        low_d = '0;
        if (!sirq_hi) begin
          st_d = SIRQCR_START;
          low_d = LOW_CNT_W'(1);
          carry_d = pend;
        end else if (quiet_q && pend && !soe_q) begin
          // one clock low only, then the line is left to the host
          so_d = 1'b0; // self start allowed only in quiet mode
          soe_d = 1'b1;
        end
      end
      SIRQCR_START: begin
        if (!sirq_hi) low_d = low_q + LOW_CNT_W'(1);
        else if (low_q >= LOW_CNT_W'(START_MIN_LOW)) begin
          st_d = SIRQCR_FRAMES;
          slot_d = SLOT_CNT_W'(1);
        end else st_d = SIRQCR_IDLE;
      end
      SIRQCR_FRAMES: begin
        slot_d = slot_q + SLOT_CNT_W'(1);
        // slot counts clocks after the start rising edge; phase 2 of frame k is sample
        if (ph == 2'd2 && frame >= 8'd1 && frame <= 8'(N_IRQ - 1)) begin
          drove_d = ~irq_b[frame[3:0]];
          so_d = 1'b0;
          soe_d = ~irq_b[frame[3:0]];
        end else if (ph == 2'd0 && drove_q) begin
          so_d = 1'b1;
          soe_d = 1'b1;
          drove_d = 1'b0;
        end
        if (slot_q >= SLOT_CNT_W'(FRAME_CLOCKS * NUM_FRAMES)) begin
          st_d = SIRQCR_STOP_WAIT;
          if (carry_q) clr_d = 1'b1;
        end
      end
      SIRQCR_STOP_WAIT: begin
        low_d = '0;
        if (!sirq_hi) begin
          st_d = SIRQCR_STOP_LOW;
          low_d = LOW_CNT_W'(1);
        end
      end
      SIRQCR_STOP_LOW: begin
        if (!sirq_hi) low_d = low_q + LOW_CNT_W'(1);
        else begin
          st_d = SIRQCR_IDLE;
          if (low_q == LOW_CNT_W'(STOP_QUIET_LOW)) quiet_d = 1'b1;
          else if (low_q == LOW_CNT_W'(STOP_CONT_LOW)) quiet_d = 1'b0;
        end
      end
      default: st_d = SIRQCR_IDLE;
    endcase
    if (in_rst || !SERIAL_IRQ_ENABLE) begin
      st_d = SIRQCR_IDLE;
      quiet_d = MODE_QUIET_RST;
      soe_d = 1'b0;
      drove_d = 1'b0;
      carry_d = 1'b0;
    end
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= SIRQCR_IDLE;
      low_q <= '0;
      slot_q <= '0;
      quiet_q <= MODE_QUIET_RST;
      so_q <= 1'b1;
      soe_q <= 1'b0;
      drove_q <= 1'b0;
      clr_q <= 1'b0;
      carry_q <= 1'b0;
    end else begin
      st_q <= st_d;
      low_q <= low_d;
      slot_q <= slot_d;
      quiet_q <= quiet_d;
      so_q <= so_d;
      soe_q <= soe_d;
      drove_q <= drove_d;
      clr_q <= clr_d;
      carry_q <= carry_d;
    end
  end
  assign chg.clear = clr_q;
  // clock-run request: async set when idle-high seen, released after two edges
  logic [1:0] hi_cnt_q, hi_cnt_d;
  logic       armed;
  logic       req_async;
  logic [1:0] hold_q;
  logic       cr_en;
  assign cr_en = SERIAL_IRQ_ENABLE & (PIN_MUX_SEL == PIN_SEL_CLKRUN);
  always_comb begin
    hi_cnt_d = hi_cnt_q;
    if (!crn_hi) hi_cnt_d = 2'h0;
    else if (hi_cnt_q != 2'(CLKRUN_IDLE_EDGES)) hi_cnt_d = hi_cnt_q + 2'h1;
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) hi_cnt_q <= 2'h0;
    else hi_cnt_q <= hi_cnt_d;
  end
  // a stale count right after our own release must not re-arm the request
  assign armed = (hi_cnt_q == 2'(CLKRUN_IDLE_EDGES)) & crn_hi;
  // asynchronous assert from the raw pending level; line must read high
  assign req_async = cr_en & armed & chg.pending & CLKRUN_N_I & ~in_rst;
  // request caught at once: the line then reads low and can no longer hold it
  always_ff @(posedge CLK or negedge RST_N or posedge req_async) begin
    if (!RST_N) begin
      hold_q <= 2'h0;
    end else if (req_async) begin
      hold_q <= 2'h1;
    end else if (hold_q != 2'h0) begin
      hold_q <= (hold_q == 2'(CLKRUN_HOLD_EDGES)) ? 2'h0 : hold_q + 2'h1;
    end
  end
  logic drv_cr;
  assign drv_cr = cr_en & (hold_q != 2'h0);
  always_comb begin
    SIRQ_O      = so_q;
    SIRQ_OE     = soe_q & ~in_rst & rst_all_n;
    CLKRUN_N_O  = (PIN_MUX_SEL == PIN_SEL_CLKRUN) ? 1'b0 : ADDRESS_DECODE_OUTPUT;
    CLKRUN_N_OE = (PIN_MUX_SEL == PIN_SEL_CLKRUN) ? drv_cr : 1'b1;
    QUIET_MODE  = quiet_q;
  end
endmodule
